// file: mdi_irq_ctrl.sv
// Interrupt signalling logic: status latching, masking, pulse timing, repeats
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - In Normal and Stop, each interrupt drives the line low for the pulse low time.
// - Between two pulses the line stays high at least the gap time.
// - Raising an interrupt never changes the device operating mode.
// - Mask register enables the supply, thermal, bridge and link-error groups.
// - Latched wake events interrupt only when their source is enabled as wake source.
// - Group method and wake method trigger interrupts side by side.
// - Power-on, regulator faults and level-two shutdown never make a pulse.
// - Only link frame and checksum failures cause periodic repeat pulses.
// - No pulses in Restart, Fail-Safe or Sleep mode.
// - Entering Stop with uncleared wake or brake bits issues a pulse.
// - Readable status registers update at every falling edge of the pulse.
// - Every latched event stays latched until the host clears its register.
// - During Init the interrupt pin is sampled as development mode selector.
// - While link error status stays uncleared, extra pulses are generated periodically.
// - Cyclic interrupt enable bit switches periodic repeats off.
// - Events while the line is low merge into the current pulse.
// - Wake pin edges interrupt in Normal/Stop, wake the device in Sleep/Fail-Safe.
// - Init to Normal with static sensing and high wake pin sets flag, interrupts.
module mdi_irq_ctrl
  import mdi_pkg::*;
#(
  parameter int unsigned LOW_CYC = LOW_CYC_DEF,
  parameter int unsigned GAP_CYC = GAP_CYC_DEF,
  parameter int unsigned REPEAT_CYC = REPEAT_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] dev_mode,
  input wire logic [7:0] sup_evt,
  input wire logic [3:0] therm_evt,
  input wire logic [7:0] drain_evt,
  input wire logic [1:0] dev_evt,
  input wire logic timer_wake_evt,
  input wire logic wake_pin_filt,
  input wire logic irq_pin_in,
  output logic irq_out_low,
  output logic irq_oe,
  output logic wake_req,
  output logic sw_dev_sel
);

  logic [CTRL_W-1:0] ctrl;
  logic [STAT_W-1:0] live;
  logic [STAT_W-1:0] snap;
  logic [2:0] mode_q;
  logic wk_q;
  logic pend;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] cyc_cnt;
  mdi_state_t state;
  mdi_state_t next_state;
  logic [CNT_W-1:0] next_cnt;
  logic next_pend;

  // Bus decode; a write lands only at the edge that sees waitrequest low
  wire do_wr = avs_write & ~avs_waitrequest;
  wire bus_req = avs_read | avs_write;
  wire sel_ctrl = (avs_address == OFS_CTRL);
  wire sel_sup = (avs_address == OFS_SUP);
  wire sel_therm = (avs_address == OFS_THERM);
  wire sel_drain = (avs_address == OFS_DRAIN);
  wire sel_dev = (avs_address == OFS_DEV);
  wire sel_wake = (avs_address == OFS_WAKE);
  wire sel_state = (avs_address == OFS_STATE);
  wire [3:0] grp_mask = ctrl[CTRL_MASK_LSB +: 4];
  wire [2:0] wake_en = ctrl[CTRL_WAKE_EN_LSB +: 3];

  // Write-one-to-clear, each register onto its slice of the packed vector
  wire [STAT_W-1:0] clr_sel = {
    sel_wake ? avs_writedata[2:0] : 3'h0,
    sel_dev ? avs_writedata[1:0] : 2'h0,
    sel_drain ? avs_writedata[7:0] : 8'h0,
    sel_therm ? avs_writedata[3:0] : 4'h0,
    sel_sup ? avs_writedata[7:0] : 8'h0};
  wire [STAT_W-1:0] clr_vec = clr_sel & {STAT_W{do_wr}};

  // Software reads the snapshot, not the live bits
  wire [31:0] rd_val =
    sel_ctrl ? {22'h000000, ctrl} :
    sel_sup ? {24'h000000, snap[SUP_LSB +: 8]} :
    sel_therm ? {28'h0000000, snap[THERM_LSB +: 4]} :
    sel_drain ? {24'h000000, snap[DRAIN_LSB +: 8]} :
    sel_dev ? {30'h00000000, snap[DEV_LSB +: 2]} :
    sel_wake ? {29'h00000000, snap[WAKE_LSB +: 3]} :
    sel_state ? {26'h0000000, sw_dev_sel, pend, state, irq_out_low} :
    32'h00000000;

  // Mode qualification; the block only reads the mode, it never drives it
  wire mode_ok = (dev_mode == MODE_NORMAL) || (dev_mode == MODE_STOP);
  wire mode_sleepy = (dev_mode == MODE_SLEEP) || (dev_mode == MODE_FAILSAFE);
  wire wk_edge = wake_pin_filt ^ wk_q;

  // Static sensing: high pin on Init to Normal counts as a wake event
  wire wk_static = (mode_q == MODE_INIT) && (dev_mode == MODE_NORMAL) &&
    ctrl[CTRL_STATIC] && wake_pin_filt;
  wire brake_evt = ctrl[CTRL_BRAKE_EN] && |(drain_evt & DRAIN_BRAKE_BITS);

  // Wake bits latch only for sources enabled as wake source
  wire [2:0] wake_set = {
    brake_evt & wake_en[WAKE_BRAKE],
    timer_wake_evt & wake_en[WAKE_TIMER],
    ((wk_edge & mode_ok) | wk_static) & wake_en[WAKE_PIN]};
  wire [STAT_W-1:0] set_vec = {wake_set, dev_evt, drain_evt, therm_evt, sup_evt};
  wire [STAT_W-1:0] next_live = set_vec | (live & ~clr_vec);

  // Group hits skip the bits that force Restart or Fail-Safe, and power-on
  wire [3:0] grp_hit = {
    |dev_evt & grp_mask[3],
    |drain_evt & grp_mask[2],
    |(therm_evt & THERM_IRQ_BITS) & grp_mask[1],
    |(sup_evt & SUP_IRQ_BITS) & grp_mask[0]};
  wire evt_hit = (|grp_hit) | (|wake_set);

  // Stop entry with leftovers in the wake or brake bits
  wire stop_hit = (dev_mode == MODE_STOP) && (mode_q != MODE_STOP) &&
    ((|live[WAKE_LSB +: 3]) || (|(live[DRAIN_LSB +: 8] & DRAIN_BRAKE_BITS)));

  // Repeats follow only the link failure bits, gated by their mask too
  wire cyc_on = ctrl[CTRL_CYC_EN] && grp_mask[3] &&
    (|live[DEV_LSB +: 2]) && mode_ok;
  wire cyc_fire = cyc_on && (cyc_cnt == CNT_W'(REPEAT_CYC - 1));
  wire trig = mode_ok && (evt_hit || stop_hit || cyc_fire);
  wire pulse_start = (next_state == ST_LOW) && (state != ST_LOW);

  // Pulse sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt + 24'h000001;
    next_pend = (pend | trig) & mode_ok;
    case (state)
      ST_IDLE: begin
        next_cnt = 24'h000000;
        if (next_pend) begin
          next_state = ST_LOW;
          next_pend = 1'b0;
        end
      end
      ST_LOW: begin
        next_pend = 1'b0;
        if (cnt == CNT_W'(LOW_CYC - 1) || !mode_ok) begin
          next_state = ST_GAP;
          next_cnt = 24'h000000;
        end
      end
      ST_GAP: begin
        if (cnt == CNT_W'(GAP_CYC - 1)) begin
          next_state = ST_IDLE;
          next_cnt = 24'h000000;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = 24'h000000;
        next_pend = 1'b0;
      end
    endcase
  end

  // Bus slave: one wait cycle, then a single cycle with waitrequest low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= rd_val;
      end
    end
  end

  // Control register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
    end else if (ce && do_wr && sel_ctrl) begin
      ctrl <= avs_writedata[CTRL_W-1:0];
    end
  end

  // Status bits: set beats a clear that lands in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < STAT_W; gi++) begin : g_stat
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          live[gi] <= 1'b0;
          snap[gi] <= 1'b0;
        end else if (ce) begin
          live[gi] <= next_live[gi];
          snap[gi] <= pulse_start ? next_live[gi] : (snap[gi] & ~clr_vec[gi]);
        end
      end
    end
  endgenerate

  // Sequencer and history registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 24'h000000;
      pend <= 1'b0;
      mode_q <= MODE_INIT;
      wk_q <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      pend <= next_pend;
      mode_q <= dev_mode;
      wk_q <= wake_pin_filt;
    end
  end

  // Repeat timer restarts whenever its condition drops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cyc_cnt <= 24'h000000;
    end else if (ce) begin
      cyc_cnt <= (cyc_on && !cyc_fire) ? cyc_cnt + 24'h000001 : 24'h000000;
    end
  end

  // Pin outputs; in Init the pin is released so the strap level can be read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_out_low <= 1'b1;
      irq_oe <= 1'b0;
      sw_dev_sel <= 1'b0;
      wake_req <= 1'b0;
    end else if (ce) begin
      irq_out_low <= (next_state != ST_LOW);
      irq_oe <= (dev_mode != MODE_INIT);
      if (dev_mode == MODE_INIT) begin
        sw_dev_sel <= irq_pin_in;
      end
      wake_req <= wk_edge & mode_sleepy & wake_en[WAKE_PIN];
    end
  end

  // Helper run counters for the timing checks below
  logic [CNT_W-1:0] low_run;
  logic [CNT_W-1:0] hi_run;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      low_run <= 24'h000000;
      hi_run <= 24'hFFFFFF;
    end else if (ce) begin
      low_run <= irq_out_low ? 24'h000000 : low_run + 24'h000001;
      if (!irq_out_low) begin
        hi_run <= 24'h000000;
      end else if (hi_run != 24'hFFFFFF) begin
        hi_run <= hi_run + 24'h000001;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_low_width;
    $rose(irq_out_low) && $past(mode_ok) |-> low_run == CNT_W'(LOW_CYC);
  endproperty
  a_low_width: assert property (p_low_width) else $error("pulse low width wrong");

  property p_gap;
    $fell(irq_out_low) |-> hi_run >= CNT_W'(GAP_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("gap between pulses too short");

  // Only excluded bits active while idle: the line must stay high next cycle
  property p_excluded;
    ce && state == ST_IDLE && !pend && !stop_hit && !cyc_fire && wake_set == 3'h0
      && (sup_evt & SUP_IRQ_BITS) == 8'h00 && (therm_evt & THERM_IRQ_BITS) == 4'h0
      && drain_evt == 8'h00 && dev_evt == 2'h0 |=> irq_out_low;
  endproperty
  a_excluded: assert property (p_excluded) else $error("excluded flag raised irq");

  property p_quiet_modes;
    $fell(irq_out_low) |-> $past(mode_ok);
  endproperty
  a_quiet_modes: assert property (p_quiet_modes) else $error("pulse in quiet mode");

  property p_stop_entry;
    ce && stop_hit && state == ST_IDLE |=> !irq_out_low;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("no pulse on stop entry");

  property p_snapshot;
    $fell(irq_out_low) |-> snap == $past(next_live);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

  property p_latched;
    ce |=> (~live & $past(live & ~clr_vec)) == 25'h0000000;
  endproperty
  a_latched: assert property (p_latched) else $error("status bit lost");

  property p_cyc_off;
    ce && !ctrl[CTRL_CYC_EN] |=> cyc_cnt == 24'h000000;
  endproperty
  a_cyc_off: assert property (p_cyc_off) else $error("repeat while disabled");

  property p_merge;
    ce && state == ST_LOW && trig |=> !pend;
  endproperty
  a_merge: assert property (p_merge) else $error("event during pulse kept");

  property p_wake_off;
    ce && !wake_en[WAKE_PIN] |=> live[WAKE_LSB] == $past(live[WAKE_LSB] & ~clr_vec[WAKE_LSB]);
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("disabled wake latched");

  property p_init_released;
    ce && dev_mode == MODE_INIT |=> !irq_oe;
  endproperty
  a_init_released: assert property (p_init_released) else $error("pin driven in init");

  property p_wake_drive;
    ce && wk_edge && mode_sleepy && wake_en[WAKE_PIN] |=> wake_req;
  endproperty
  a_wake_drive: assert property (p_wake_drive) else $error("wake edge not signalled");

  c_pulse: cover property ($fell(irq_out_low));
  c_repeat: cover property (cyc_fire);
  c_stop: cover property (stop_hit);
  c_merge: cover property (state == ST_LOW && evt_hit);
  c_wake: cover property (wake_req);

endmodule

`default_nettype wire

// file: mdi_pkg.sv
// Constants and types shared by the motor driver interrupt signalling block
package mdi_pkg;

  // Clock and timing figures; the times are in ns
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PULSE_LOW_NS = 100000;
  localparam int unsigned PULSE_GAP_NS = 50000;
  localparam int unsigned REPEAT_NS = 10000000;
  // Least times round up to whole cycles
  localparam int unsigned LOW_CYC_DEF = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC_DEF = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REPEAT_CYC_DEF = (REPEAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SUP = 5'h04;
  localparam logic [4:0] OFS_THERM = 5'h08;
  localparam logic [4:0] OFS_DRAIN = 5'h0C;
  localparam logic [4:0] OFS_DEV = 5'h10;
  localparam logic [4:0] OFS_WAKE = 5'h14;
  localparam logic [4:0] OFS_STATE = 5'h18;

  // Control register layout
  localparam int CTRL_W = 10;
  localparam int CTRL_MASK_LSB = 0;
  localparam int CTRL_CYC_EN = 4;
  localparam int CTRL_WAKE_EN_LSB = 5;
  localparam int CTRL_BRAKE_EN = 8;
  localparam int CTRL_STATIC = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h03F;

  // Packed layout of all latched status bits
  localparam int SUP_LSB = 0;
  localparam int THERM_LSB = 8;
  localparam int DRAIN_LSB = 12;
  localparam int DEV_LSB = 20;
  localparam int WAKE_LSB = 22;
  localparam int STAT_W = 25;

  // Bits that may raise an interrupt in the supply and thermal groups, the brake bits and the wake source indices
  localparam logic [7:0] SUP_IRQ_BITS = 8'hF0;
  localparam logic [3:0] THERM_IRQ_BITS = 4'h7;
  localparam logic [7:0] DRAIN_BRAKE_BITS = 8'hE0;
  localparam int WAKE_PIN = 0;
  localparam int WAKE_TIMER = 1;
  localparam int WAKE_BRAKE = 2;

  typedef enum logic [2:0] {
    MODE_INIT = 3'h0,
    MODE_NORMAL = 3'h1,
    MODE_STOP = 3'h2,
    MODE_SLEEP = 3'h3,
    MODE_RESTART = 3'h4,
    MODE_FAILSAFE = 3'h5
  } mdi_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOW = 3'h2,
    ST_GAP = 3'h4
  } mdi_state_t;

endpackage

// file: mdi_host_model.sv
// Host side model: watches the interrupt line and measures its pulses
`timescale 1ns/1ps
`default_nettype none
module mdi_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic irq_out_low,
  input wire logic irq_oe,
  output logic [15:0] n_pulse,
  output logic [15:0] low_len,
  output logic [15:0] min_gap
);
  logic [15:0] run;
  logic prev;
  // Counts falls and the length of each low and high phase; the line only
  // counts while driven, since in Init the pin is a strap input
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      n_pulse <= 16'h0000;
      low_len <= 16'h0000;
      min_gap <= 16'hFFFF;
      run <= 16'h0001;
      prev <= 1'b1;
    end else begin
      prev <= irq_out_low;
      run <= (irq_out_low != prev) ? 16'h0001 : run + 16'h0001;
      if (prev && !irq_out_low && irq_oe) begin
        n_pulse <= n_pulse + 16'h0001;
        if (run < min_gap) min_gap <= run;
      end
      // The run already counts every sample of the phase that just ended
      if (!prev && irq_out_low) low_len <= run;
    end
  end
endmodule
`default_nettype wire

// file: mdi_irq_ctrl_tb_top.sv
// Self-checking bench for the interrupt signalling block
`timescale 1ns/1ps
`default_nettype none
module mdi_irq_ctrl_tb_top
  import mdi_pkg::*;
;
  localparam int unsigned LOW = 8;
  localparam int unsigned GAP = 5;
  localparam int unsigned REP = 60;
  typedef struct packed {
    logic [2:0] md;
    logic [22:0] ev;
    logic [9:0] ctl;
    logic [7:0] np;
    logic [4:0] ofs;
    logic [7:0] rd;
  } mdi_row_t;
  logic sys_clk = 1'b0;
  logic ce = 1'b1;
  logic rst_n, avs_read, avs_write, avs_waitrequest, wake, strap, pin;
  logic irq_out_low, irq_oe, wake_req, sw_dev_sel, seen;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] dev_mode;
  logic [22:0] ev;
  logic [15:0] n_pulse, low_len, min_gap, base;
  int n_errors = 0;
  int checked = 0;
  mdi_row_t rows [13];
  // Pin level: the block drives it except in Init, where the strap shows
  assign pin = irq_oe ? irq_out_low : strap;
  always #2.5 sys_clk = ~sys_clk;
  mdi_irq_ctrl #(.LOW_CYC(LOW), .GAP_CYC(GAP), .REPEAT_CYC(REP)) u_mdi_irq_ctrl (
    .sys_clk, .rst_n, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .dev_mode, .sup_evt(ev[7:0]), .therm_evt(ev[11:8]),
    .drain_evt(ev[19:12]), .dev_evt(ev[21:20]), .timer_wake_evt(ev[22]),
    .wake_pin_filt(wake), .irq_pin_in(pin), .irq_out_low, .irq_oe, .wake_req, .sw_dev_sel);
  mdi_host_model u_mdi_host_model (.sys_clk, .rst_n, .irq_out_low, .irq_oe, .n_pulse,
    .low_len, .min_gap);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One Avalon access; waitrequest and read data are taken at the rising edge,
  // then one idle edge keeps a following call from re-raising in the same step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic pulse(input logic [22:0] v);
    ev <= v;
    @(posedge sys_clk);
    ev <= 23'h000000;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the under two thousand cycles the tests need
  initial begin
    #150000;
    n_errors++;
    final_report;
  end
  initial begin
    rows[0] = '{MODE_NORMAL, 23'h000010, 10'h03F, 8'h01, OFS_SUP, 8'h10};
    rows[1] = '{MODE_NORMAL, 23'h000001, 10'h03F, 8'h00, OFS_SUP, 8'h00};
    rows[2] = '{MODE_NORMAL, 23'h000800, 10'h03F, 8'h00, OFS_THERM, 8'h00};
    rows[3] = '{MODE_NORMAL, 23'h000200, 10'h03F, 8'h01, OFS_THERM, 8'h02};
    rows[4] = '{MODE_NORMAL, 23'h001000, 10'h03F, 8'h01, OFS_DRAIN, 8'h01};
    rows[5] = '{MODE_NORMAL, 23'h200000, 10'h03F, 8'h01, OFS_DEV, 8'h02};
    rows[6] = '{MODE_NORMAL, 23'h000010, 10'h03E, 8'h00, OFS_SUP, 8'h00};
    rows[7] = '{MODE_SLEEP, 23'h000010, 10'h03F, 8'h00, OFS_SUP, 8'h00};
    rows[8] = '{MODE_RESTART, 23'h000200, 10'h03F, 8'h00, OFS_THERM, 8'h00};
    rows[9] = '{MODE_FAILSAFE, 23'h001000, 10'h03F, 8'h00, OFS_DRAIN, 8'h00};
    rows[10] = '{MODE_STOP, 23'h000100, 10'h03F, 8'h01, OFS_THERM, 8'h01};
    rows[11] = '{MODE_NORMAL, 23'h400000, 10'h03F, 8'h00, OFS_WAKE, 8'h00};
    rows[12] = '{MODE_NORMAL, 23'h400000, 10'h07F, 8'h01, OFS_WAKE, 8'h02};
    {avs_read, avs_write, wake, strap} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    ev = 23'h000000;
    dev_mode = MODE_INIT;
    rst_n = 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, unmapped space and the Init strap
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h3F, q);
    bus(1'b0, 5'h1C, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("state", 32'h3, q);
    strap <= 1'b1;
    cyc(3);
    chk("strap", 32'h1, 32'(sw_dev_sel));
    chk("oe init", 32'h0, 32'(irq_oe));
    // Static sensing with the pin high at the change to Normal
    bus(1'b1, OFS_CTRL, 32'h23F);
    wake <= 1'b1;
    cyc(3);
    base = n_pulse;
    dev_mode <= MODE_NORMAL;
    cyc(20);
    chk("init wake", 32'h1, 32'(n_pulse - base));
    bus(1'b0, OFS_WAKE, 32'h0);
    chk("wake flag", 32'h1, q);
    bus(1'b1, OFS_WAKE, 32'hFF);
    base = n_pulse;
    wake <= 1'b0;
    cyc(20);
    chk("pin edge", 32'h1, 32'(n_pulse - base));
    bus(1'b1, OFS_WAKE, 32'hFF);
    $display("reset and wake pin tests done");
    // Table of single events across groups, masks and modes
    foreach (rows[i]) begin
      bus(1'b1, OFS_CTRL, 32'(rows[i].ctl));
      dev_mode <= rows[i].md;
      cyc(2);
      base = n_pulse;
      pulse(rows[i].ev);
      cyc(20);
      chk("pulses", 32'(rows[i].np), 32'(n_pulse - base));
      bus(1'b0, rows[i].ofs, 32'h0);
      chk("status", 32'(rows[i].rd), q);
      bus(1'b1, rows[i].ofs, 32'hFF);
      bus(1'b0, rows[i].ofs, 32'h0);
      chk("cleared", 32'h0, q);
      $display("row %0d done", i);
    end
    // Events merged while low, then one waiting out the gap
    dev_mode <= MODE_NORMAL;
    bus(1'b1, OFS_CTRL, 32'h3F);
    base = n_pulse;
    pulse(23'h000010);
    cyc(3);
    pulse(23'h000100);
    cyc(7);
    pulse(23'h000020);
    cyc(30);
    chk("merge", 32'h2, 32'(n_pulse - base));
    chk("low len", 32'(LOW), 32'(low_len));
    chk("gap", 32'h1, 32'(min_gap >= GAP + 1));
    bus(1'b1, OFS_SUP, 32'hFF);
    bus(1'b1, OFS_THERM, 32'hFF);
    // Repeats while link errors stay latched, then switched off
    base = n_pulse;
    pulse(23'h100000);
    cyc(200);
    chk("repeat", 32'h1, 32'(n_pulse - base >= 3));
    bus(1'b1, OFS_CTRL, 32'h2F);
    base = n_pulse;
    cyc(200);
    chk("no repeat", 32'h0, 32'(n_pulse - base));
    bus(1'b1, OFS_DEV, 32'hFF);
    bus(1'b1, OFS_CTRL, 32'h3F);
    base = n_pulse;
    pulse(23'h000010);
    cyc(200);
    chk("supply once", 32'h1, 32'(n_pulse - base));
    bus(1'b1, OFS_SUP, 32'hFF);
    // Clock enable low for ten cycles stretches a pulse by exactly that much
    pulse(23'h000010);
    cyc(2);
    ce <= 1'b0;
    cyc(10);
    chk("frozen", 32'h0, 32'(irq_out_low));
    ce <= 1'b1;
    cyc(30);
    chk("frozen len", 32'(LOW + 10), 32'(low_len));
    bus(1'b1, OFS_SUP, 32'hFF);
    $display("merge and repeat tests done");
    // Stop entry with a wake flag left uncleared
    bus(1'b1, OFS_CTRL, 32'h7F);
    pulse(23'h400000);
    cyc(20);
    dev_mode <= MODE_SLEEP;
    cyc(5);
    base = n_pulse;
    wake <= 1'b1;
    seen = 1'b0;
    repeat (5) begin
      @(negedge sys_clk);
      if (wake_req === 1'b1) seen = 1'b1;
    end
    chk("sleep wake", 32'h1, 32'(seen));
    @(posedge sys_clk);
    dev_mode <= MODE_STOP;
    cyc(20);
    chk("stop entry", 32'h1, 32'(n_pulse - base));
    bus(1'b1, OFS_WAKE, 32'hFF);
    $display("stop entry test done");
    final_report;
  end
endmodule
`default_nettype wire
